// *** hdl/chip_select_pkg.sv ***
// Constants, field layouts and types shared by the chip-select decoder.
package chip_select_pkg;

  // ****************************************
  // Control register selection codes
  // ****************************************
  localparam logic [2:0] REG_UPPER  = 3'h0;
  localparam logic [2:0] REG_LOW    = 3'h1;
  localparam logic [2:0] REG_MID    = 3'h2;
  localparam logic [2:0] REG_AUX    = 3'h3;
  localparam logic [2:0] REG_PERIPH = 3'h4;

  // ****************************************
  // Field positions of the wait and ready fields; the extended wait bit is used by the peripheral base register only
  // ****************************************
  localparam int WAIT_COUNT_LSB    = 0;
  localparam int EXT_READY_USE_BIT = 2;
  localparam int EXTENDED_WAIT_BIT = 3;

  // ****************************************
  // Field positions of individual registers
  // ****************************************
  localparam int UPPER_BOUND_LSB  = 6;
  localparam int LOW_TOP_LSB      = 6;
  localparam int MID_BASE_LSB     = 9;
  localparam int AUX_SIZE_LSB     = 8;
  localparam int AUX_ADDR_PIN_BIT = 7;
  localparam int AUX_IO_SPACE_BIT = 6;
  localparam int PERIPH_BASE_LSB  = 7;

  // ****************************************
  // Reset values and midrange size constants
  // ****************************************
  localparam logic [15:0] UPPER_RESET  = 16'h01C7;
  localparam logic [15:0] OTHER_RESET  = 16'h0000;
  localparam logic [19:0] MID_UNIT     = 20'h02000;
  localparam logic [2:0]  MID_SIZE_MAX = 3'h6;

  // ****************************************
  // Wait-state sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    WS_IDLE  = 3'b001,
    WS_COUNT = 3'b010,
    WS_READY = 3'b100
  } wait_state_t;

endpackage

// *** hdl/chip_select_decoder.sv ***
// Chip-select decoder with per-group ready and wait-state sequencing.
//
// Overview of operation
// - Upper select active from reset, default window F0000h to FFFFFh.
// - Upper select resets with external ready required and three wait states.
// - Upper window lower boundary programmable, top fixed, 64 to 512 Kbytes.
// - Reset fetch address FFFF0h lies inside the default upper window.
// - Low select inactive after reset until its control register is accessed.
// - Four midrange selects decode one user-placed block in memory space.
// - With peripherals in I/O space, midrange block may overlap their range.
// - Midrange size from auxiliary register; base, ready, waits from midrange.
// - Midrange selects stay inactive until both their registers are accessed.
// - Midrange selects assert one step later than upper and low selects.
// - Peripheral block base lies in memory space or in I/O space.
// - Peripheral base register gives base, ready, waits for four low selects.
// - Auxiliary bit turns upper two peripheral pins into latched address bits.
// - Auxiliary register picks space, ready and waits for upper two selects.
// - Peripheral selects inactive until peripheral and auxiliary registers accessed.
// - Upper peripheral pair 0-3 waits; low four also 5, 7, 9, 15.
// - Bit 2 requests external ready; bits 1 to 0 give wait count.
// - Programmed waits always finish before external ready ends the cycle.
// - Reading or writing a control register enables its decode, ready and wait logic.
`timescale 1ns/1ps
`default_nettype none

module chip_select_decoder
  import chip_select_pkg::*;
#(
  parameter int ADDR_W = 20
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  // Control register access
  input  wire logic              ctl_write_i,
  input  wire logic              ctl_read_i,
  input  wire logic [2:0]        ctl_sel_i,
  input  wire logic [15:0]       ctl_wdata_i,
  output logic      [15:0]       ctl_rdata_o,
  // Bus cycle
  input  wire logic              addr_valid_i,
  input  wire logic              cycle_start_i,
  input  wire logic              io_cycle_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              ext_ready_i,
  output logic                   cycle_done_o,
  output logic                   wait_busy_o,
  // Select pins
  output logic                   upper_select_n_o,
  output logic                   low_select_n_o,
  output logic      [3:0]        mid_mem_selects_n_o,
  output logic      [3:0]        periph_selects_low_n_o,
  output logic                   periph_select_hi_a_o,
  output logic                   periph_select_hi_b_o
);

  // ****************************************
  // Elaboration check
  // ****************************************
  if (ADDR_W != 20) begin : g_bad_width
    $error("chip_select_decoder serves a 20-bit address only");
  end

  // ****************************************
  // Control registers and enables
  // ****************************************
  logic [15:0] upper_select_control_reg;
  logic [15:0] low_select_control_reg;
  logic [15:0] mid_select_control_reg;
  logic [15:0] aux_select_control_reg;
  logic [15:0] periph_base_control_reg;
  logic        low_seen_reg;
  logic        mid_seen_reg;
  logic        aux_seen_reg;
  logic        periph_seen_reg;
  logic        ctl_touch;

  assign ctl_touch = ctl_write_i | ctl_read_i;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      upper_select_control_reg <= UPPER_RESET;
      low_select_control_reg   <= OTHER_RESET;
      mid_select_control_reg   <= OTHER_RESET;
      aux_select_control_reg   <= OTHER_RESET;
      periph_base_control_reg  <= OTHER_RESET;
    end else if (ctl_write_i) begin
      case (ctl_sel_i)
        REG_UPPER:  upper_select_control_reg <= ctl_wdata_i;
        REG_LOW:    low_select_control_reg   <= ctl_wdata_i;
        REG_MID:    mid_select_control_reg   <= ctl_wdata_i;
        REG_AUX:    aux_select_control_reg   <= ctl_wdata_i;
        REG_PERIPH: periph_base_control_reg  <= ctl_wdata_i;
        default: begin
        end
      endcase
    end
  end

  // Any access, read or write, arms the group; there are no pins to share here.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      low_seen_reg    <= 1'b0;
      mid_seen_reg    <= 1'b0;
      aux_seen_reg    <= 1'b0;
      periph_seen_reg <= 1'b0;
    end else if (ctl_touch) begin
      if (ctl_sel_i == REG_LOW)    low_seen_reg    <= 1'b1;
      if (ctl_sel_i == REG_MID)    mid_seen_reg    <= 1'b1;
      if (ctl_sel_i == REG_AUX)    aux_seen_reg    <= 1'b1;
      if (ctl_sel_i == REG_PERIPH) periph_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctl_rdata_o <= 16'h0000;
    end else if (ctl_read_i) begin
      case (ctl_sel_i)
        REG_UPPER:  ctl_rdata_o <= upper_select_control_reg;
        REG_LOW:    ctl_rdata_o <= low_select_control_reg;
        REG_MID:    ctl_rdata_o <= mid_select_control_reg;
        REG_AUX:    ctl_rdata_o <= aux_select_control_reg;
        REG_PERIPH: ctl_rdata_o <= periph_base_control_reg;
        default:    ctl_rdata_o <= 16'h0000;
      endcase
    end
  end

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic [3:0] wait_of(input logic [15:0] ctl, input logic ext_ok);
    logic [1:0] code;
    code = ctl[WAIT_COUNT_LSB +: 2];
    if (ext_ok && ctl[EXTENDED_WAIT_BIT]) begin
      case (code)
        2'h0:    wait_of = 4'h5;
        2'h1:    wait_of = 4'h7;
        2'h2:    wait_of = 4'h9;
        default: wait_of = 4'hF;
      endcase
    end else begin
      wait_of = {2'b00, code};
    end
  endfunction

  logic        mid_en;
  logic        periph_en;
  logic        hi_as_addr;
  logic        mem_cycle;
  logic        upper_hit;
  logic        low_hit;
  logic        mid_hit;
  logic        periph_blk;
  logic [2:0]  mid_size;
  logic [19:0] mid_mask;
  logic [19:0] mid_shifted;
  logic [2:0]  periph_idx;
  logic [6:0]  periph_hit;
  logic [3:0]  sel_wait;
  logic        sel_ready;

  assign mid_en     = mid_seen_reg & aux_seen_reg;
  assign periph_en  = periph_seen_reg & aux_seen_reg;
  assign hi_as_addr = aux_select_control_reg[AUX_ADDR_PIN_BIT];
  assign mem_cycle  = ~io_cycle_i;

  always_comb begin
    mid_size = aux_select_control_reg[AUX_SIZE_LSB +: 3];
    if (mid_size > MID_SIZE_MAX) begin
      mid_size = MID_SIZE_MAX;
    end
    mid_mask    = ~((MID_UNIT << mid_size) - 20'h00001);
    mid_shifted = addr_i >> (5'd11 + {2'b00, mid_size});
    periph_idx  = addr_i[10:8];
    // Top of memory is fixed; the boundary MSB is forced so the window stays 64-512K.
    upper_hit = mem_cycle &&
                (addr_i[19:16] >= {1'b1, upper_select_control_reg[UPPER_BOUND_LSB +: 3]});
    low_hit   = low_seen_reg && mem_cycle &&
                (addr_i[19:16] <= low_select_control_reg[LOW_TOP_LSB +: 4]);
    // Midrange decodes memory cycles only, so an I/O peripheral block never collides.
    mid_hit   = mid_en && mem_cycle &&
                (((addr_i ^ {mid_select_control_reg[MID_BASE_LSB +: 7], 13'h0000}) & mid_mask)
                 == 20'h00000);
    periph_blk = periph_en &&
                 (aux_select_control_reg[AUX_IO_SPACE_BIT] ? io_cycle_i : mem_cycle) &&
                 (addr_i[19:11] == periph_base_control_reg[PERIPH_BASE_LSB +: 9]);
    periph_hit = 7'h00;
    if (periph_blk) begin
      periph_hit[periph_idx] = 1'b1;
    end
    // Fixed priority merges overlapping windows; software keeps them consistent.
    if (upper_hit) begin
      sel_wait  = wait_of(upper_select_control_reg, 1'b0);
      sel_ready = upper_select_control_reg[EXT_READY_USE_BIT];
    end else if (low_hit) begin
      sel_wait  = wait_of(low_select_control_reg, 1'b0);
      sel_ready = low_select_control_reg[EXT_READY_USE_BIT];
    end else if (mid_hit) begin
      sel_wait  = wait_of(mid_select_control_reg, 1'b0);
      sel_ready = mid_select_control_reg[EXT_READY_USE_BIT];
    end else if (periph_blk && (periph_idx <= 3'h4)) begin
      sel_wait  = wait_of(periph_base_control_reg, 1'b1);
      sel_ready = periph_base_control_reg[EXT_READY_USE_BIT];
    end else if (periph_blk && !hi_as_addr && (periph_idx != 3'h7)) begin
      sel_wait  = wait_of(aux_select_control_reg, 1'b0);
      sel_ready = aux_select_control_reg[EXT_READY_USE_BIT];
    end else begin
      sel_wait  = 4'h0;
      sel_ready = 1'b0;
    end
  end

  // ****************************************
  // Select outputs
  // ****************************************
  logic [3:0] mid_stage_n;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      upper_select_n_o       <= 1'b1;
      low_select_n_o         <= 1'b1;
      mid_stage_n            <= 4'hF;
      periph_selects_low_n_o <= 4'hF;
      periph_select_hi_a_o   <= 1'b1;
      periph_select_hi_b_o   <= 1'b1;
    end else begin
      upper_select_n_o       <= ~(addr_valid_i & upper_hit);
      low_select_n_o         <= ~(addr_valid_i & low_hit);
      mid_stage_n            <= 4'hF;
      if (addr_valid_i && mid_hit) begin
        mid_stage_n[mid_shifted[1:0]] <= 1'b0;
      end
      periph_selects_low_n_o <= ~({4{addr_valid_i}} & periph_hit[3:0]);
      if (hi_as_addr) begin
        periph_select_hi_a_o <= addr_i[1];
        periph_select_hi_b_o <= addr_i[2];
      end else begin
        periph_select_hi_a_o <= ~(addr_valid_i & periph_hit[5]);
        periph_select_hi_b_o <= ~(addr_valid_i & periph_hit[6]);
      end
    end
  end

  // A clock edge is the finest step here, so the half-clock lag becomes a full stage.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mid_mem_selects_n_o <= 4'hF;
    end else begin
      mid_mem_selects_n_o <= mid_stage_n | {4{~addr_valid_i}};
    end
  end

  // ****************************************
  // Wait-state sequencer
  // ****************************************
  wait_state_t ws_reg;
  logic [3:0]  ws_count_reg;
  logic [3:0]  ws_target_reg;
  logic        ws_need_reg;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ws_reg        <= WS_IDLE;
      ws_count_reg  <= 4'h0;
      ws_target_reg <= 4'h0;
      ws_need_reg   <= 1'b0;
      cycle_done_o  <= 1'b0;
      wait_busy_o   <= 1'b0;
    end else begin
      cycle_done_o <= 1'b0;
      case (ws_reg)
        WS_IDLE: begin
          if (cycle_start_i) begin
            ws_reg        <= WS_COUNT;
            ws_count_reg  <= 4'h0;
            ws_target_reg <= sel_wait;
            ws_need_reg   <= sel_ready;
            wait_busy_o   <= 1'b1;
          end
        end
        WS_COUNT: begin
          if (ws_count_reg == ws_target_reg) begin
            if (!ws_need_reg || ext_ready_i) begin
              ws_reg       <= WS_IDLE;
              cycle_done_o <= 1'b1;
              wait_busy_o  <= 1'b0;
            end else begin
              ws_reg <= WS_READY;
            end
          end else begin
            ws_count_reg <= ws_count_reg + 4'h1;
          end
        end
        WS_READY: begin
          if (ext_ready_i) begin
            ws_reg       <= WS_IDLE;
            cycle_done_o <= 1'b1;
            wait_busy_o  <= 1'b0;
          end
        end
        default: begin
          ws_reg      <= WS_IDLE;
          wait_busy_o <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_start_upper_default;
    cycle_start_i && addr_valid_i && upper_hit && !low_hit && !mid_hit && !periph_blk &&
    ws_reg == WS_IDLE && upper_select_control_reg == UPPER_RESET;
  endsequence

  a_upper_reset_window: assert property (
    $fell(reset_i) |-> upper_select_control_reg == UPPER_RESET && !low_seen_reg)
    else $error("upper select not at its reset window");
  a_upper_reset_fetch: assert property (
    addr_valid_i && mem_cycle && addr_i == 20'hFFFF0 && upper_select_control_reg == UPPER_RESET
    |=> !upper_select_n_o)
    else $error("reset fetch address not selected");
  a_upper_reset_waits: assert property (
    s_start_upper_default |=> ws_target_reg == 4'h3 && ws_need_reg)
    else $error("upper reset waits wrong");
  a_low_needs_access: assert property (
    !low_seen_reg |=> low_select_n_o)
    else $error("low select active before access");
  a_mid_needs_both: assert property (
    !mid_en |=> ##1 mid_mem_selects_n_o == 4'hF)
    else $error("midrange select active before both accesses");
  a_periph_needs_both: assert property (
    !periph_en |=> periph_selects_low_n_o == 4'hF)
    else $error("peripheral select active before both accesses");
  a_mid_lags_stage: assert property (
    mid_stage_n != 4'hF && addr_valid_i |=> mid_mem_selects_n_o == $past(mid_stage_n))
    else $error("midrange select timing wrong");
  a_selects_idle_high: assert property (
    !addr_valid_i |=> upper_select_n_o && low_select_n_o && periph_selects_low_n_o == 4'hF)
    else $error("select active outside a bus cycle");
  a_hi_pins_address: assert property (
    hi_as_addr |=> periph_select_hi_a_o == $past(addr_i[1]) &&
                   periph_select_hi_b_o == $past(addr_i[2]))
    else $error("upper peripheral pins not carrying address");
  a_waits_before_ready: assert property (
    cycle_start_i && ws_reg == WS_IDLE && sel_wait == 4'h3 |-> ##1 !cycle_done_o [*4])
    else $error("cycle ended before programmed waits");

endmodule // chip_select_decoder

`default_nettype wire

// *** test/ready_responder.sv ***
// Behavioural model of the memories and peripherals that answer with ready.
`timescale 1ns/1ps
`default_nettype none

module ready_responder (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Bus cycle as seen by the far side
  input  wire logic       cycle_start_i,
  input  wire logic       cycle_done_i,
  input  wire logic [7:0] delay_i,
  // Ready back to the decoder
  output var  logic       ext_ready_o
);
  logic       busy_reg;
  logic [7:0] count_reg;

  // ****************************************
  // Ready generation
  // ****************************************
  // Ready stays low outside a cycle, so a decoder that samples it too early gets no help.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      busy_reg    <= 1'b0;
      count_reg   <= 8'h00;
      ext_ready_o <= 1'b0;
    end else if (cycle_start_i) begin
      busy_reg    <= 1'b1;
      count_reg   <= 8'h00;
      ext_ready_o <= 1'b0;
    end else if (busy_reg && cycle_done_i) begin
      busy_reg    <= 1'b0;
      ext_ready_o <= 1'b0;
    end else if (busy_reg && count_reg == delay_i) begin
      ext_ready_o <= 1'b1;
    end else if (busy_reg) begin
      count_reg <= count_reg + 8'h01;
    end
  end
endmodule // ready_responder

`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking testbench of the chip-select decoder.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import chip_select_pkg::*;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        ctl_write_i = 1'b0;
  logic        ctl_read_i = 1'b0;
  logic [2:0]  ctl_sel_i = 3'h0;
  logic [15:0] ctl_wdata_i = 16'h0000;
  logic        addr_valid_i = 1'b0;
  logic        cycle_start_i = 1'b0;
  logic        io_cycle_i = 1'b0;
  logic [19:0] addr_i = 20'h00000;
  logic [7:0]  delay = 8'h00;
  logic        ext_ready_i;
  logic [15:0] ctl_rdata_o;
  logic        cycle_done_o;
  logic        wait_busy_o;
  logic        upper_select_n_o;
  logic        low_select_n_o;
  logic [3:0]  mid_mem_selects_n_o;
  logic [3:0]  periph_selects_low_n_o;
  logic        periph_select_hi_a_o;
  logic        periph_select_hi_b_o;
  logic [7:0]  fast_pins;
  int          failures = 0;
  int          checks_done = 0;
  int          cycles = 0;

  assign fast_pins = {upper_select_n_o, low_select_n_o, periph_selects_low_n_o,
                      periph_select_hi_a_o, periph_select_hi_b_o};

  always #4 clk_i = ~clk_i;

  chip_select_decoder i_dut (
    .clk_i(clk_i), .reset_i(reset_i), .ctl_write_i(ctl_write_i), .ctl_read_i(ctl_read_i),
    .ctl_sel_i(ctl_sel_i), .ctl_wdata_i(ctl_wdata_i), .ctl_rdata_o(ctl_rdata_o),
    .addr_valid_i(addr_valid_i), .cycle_start_i(cycle_start_i), .io_cycle_i(io_cycle_i),
    .addr_i(addr_i), .ext_ready_i(ext_ready_i), .cycle_done_o(cycle_done_o),
    .wait_busy_o(wait_busy_o),
    .upper_select_n_o(upper_select_n_o), .low_select_n_o(low_select_n_o),
    .mid_mem_selects_n_o(mid_mem_selects_n_o), .periph_selects_low_n_o(periph_selects_low_n_o),
    .periph_select_hi_a_o(periph_select_hi_a_o), .periph_select_hi_b_o(periph_select_hi_b_o)
  );

  ready_responder i_ready (
    .clk_i(clk_i), .reset_i(reset_i), .cycle_start_i(cycle_start_i),
    .cycle_done_i(cycle_done_o), .delay_i(delay), .ext_ready_o(ext_ready_i)
  );

  // ****************************************
  // Compare and bus tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [2:0] sel, input logic [15:0] data);
    @(posedge clk_i);
    ctl_write_i <= 1'b1;
    ctl_sel_i <= sel;
    ctl_wdata_i <= data;
    @(posedge clk_i);
    ctl_write_i <= 1'b0;
  endtask

  task automatic reg_rd(input logic [2:0] sel, input logic [15:0] exp);
    @(posedge clk_i);
    ctl_read_i <= 1'b1;
    ctl_sel_i <= sel;
    @(posedge clk_i);
    ctl_read_i <= 1'b0;
    #1;
    chk(ctl_rdata_o, exp);
  endtask

  // Pins are checked one edge after the address and the midrange pins one edge later still.
  task automatic probe(input logic [19:0] a, input logic io, input logic [7:0] ef,
                       input logic [3:0] em);
    @(posedge clk_i);
    addr_i <= a;
    io_cycle_i <= io;
    addr_valid_i <= 1'b1;
    @(posedge clk_i);
    #1;
    chk({8'h00, fast_pins}, {8'h00, ef});
    chk({12'h000, mid_mem_selects_n_o}, 16'h000F);
    @(posedge clk_i);
    #1;
    chk({12'h000, mid_mem_selects_n_o}, {12'h000, em});
    @(posedge clk_i);
    addr_valid_i <= 1'b0;
  endtask

  // Counts edges from the start request until the cycle may end.
  task automatic run_cycle(input logic [19:0] a, input logic io, input logic [7:0] d,
                           input int exp);
    int n;
    n = 0;
    @(posedge clk_i);
    addr_i <= a;
    io_cycle_i <= io;
    addr_valid_i <= 1'b1;
    cycle_start_i <= 1'b1;
    delay <= d;
    do begin
      @(posedge clk_i);
      cycle_start_i <= 1'b0;
      n++;
      #1;
      if (n == 1) begin
        chk({15'h0000, wait_busy_o}, 16'h0001);
      end
    end while (cycle_done_o !== 1'b1 && n < 40);
    chk_cnt(n, exp);
    chk({15'h0000, wait_busy_o}, 16'h0000);
    @(posedge clk_i);
    addr_valid_i <= 1'b0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset;
    probe(20'hFFFF0, 1'b0, 8'h7F, 4'hF);
    probe(20'hF0000, 1'b0, 8'h7F, 4'hF);
    probe(20'hEFFFF, 1'b0, 8'hFF, 4'hF);
    probe(20'hFFFF0, 1'b1, 8'hFF, 4'hF);
    probe(20'h00000, 1'b0, 8'hFF, 4'hF);
    reg_rd(REG_UPPER, 16'h01C7);
    reg_rd(3'h7, 16'h0000);
    run_cycle(20'hFFFF0, 1'b0, 8'h00, 5);
    run_cycle(20'hFFFF0, 1'b0, 8'h08, 11);
    $display("test reset done");
  endtask

  task automatic test_low_mid;
    reg_rd(REG_LOW, 16'h0000);
    probe(20'h00000, 1'b0, 8'hBF, 4'hF);
    probe(20'h10000, 1'b0, 8'hFF, 4'hF);
    reg_wr(REG_MID, 16'h2000);
    probe(20'h20800, 1'b0, 8'hFF, 4'hF);
    reg_wr(REG_AUX, 16'h0041);
    probe(20'h00100, 1'b1, 8'hFF, 4'hF);
    probe(20'h20800, 1'b0, 8'hFF, 4'hD);
    probe(20'h21800, 1'b0, 8'hFF, 4'h7);
    probe(20'h22000, 1'b0, 8'hFF, 4'hF);
    probe(20'h20800, 1'b1, 8'hFF, 4'hF);
    $display("test low and mid done");
  endtask

  task automatic test_periph;
    reg_wr(REG_PERIPH, 16'h2000);
    probe(20'h20100, 1'b1, 8'hF7, 4'hF);
    probe(20'h20100, 1'b0, 8'hFF, 4'hE);
    probe(20'h20500, 1'b1, 8'hFD, 4'hF);
    probe(20'h20600, 1'b1, 8'hFE, 4'hF);
    probe(20'h20400, 1'b1, 8'hFF, 4'hF);
    reg_wr(REG_AUX, 16'h00C1);
    probe(20'h20006, 1'b1, 8'hFB, 4'hF);
    probe(20'h20000, 1'b1, 8'hF8, 4'hF);
    reg_wr(REG_AUX, 16'h0041);
    run_cycle(20'h20500, 1'b1, 8'h00, 3);
    reg_wr(REG_AUX, 16'h0045);
    run_cycle(20'h20500, 1'b1, 8'h06, 9);
    $display("test periph done");
  endtask

  task automatic test_waits;
    int w [4] = '{5, 7, 9, 15};
    for (int e = 0; e < 4; e++) begin
      reg_wr(REG_PERIPH, 16'h2008 | 16'(e));
      run_cycle(20'h20000, 1'b1, 8'h00, w[e] + 2);
    end
    reg_wr(REG_PERIPH, 16'h2002);
    run_cycle(20'h20000, 1'b1, 8'h00, 4);
    reg_wr(REG_UPPER, 16'h0000);
    probe(20'h80000, 1'b0, 8'h7F, 4'hF);
    probe(20'h7FFFF, 1'b0, 8'hFF, 4'hF);
    run_cycle(20'h80000, 1'b0, 8'h00, 2);
    // The low window is widened over the upper one with the same zero-wait, no-ready setting.
    reg_wr(REG_LOW, 16'h03C0);
    probe(20'h80000, 1'b0, 8'h3F, 4'hF);
    run_cycle(20'h80000, 1'b0, 8'h00, 2);
    $display("test waits done");
  endtask

  // A second reset must restore the upper defaults and disarm every other group.
  task automatic test_rearm;
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    probe(20'hFFFF0, 1'b0, 8'h7F, 4'hF);
    probe(20'h00000, 1'b0, 8'hFF, 4'hF);
    probe(20'h20100, 1'b0, 8'hFF, 4'hF);
    reg_rd(REG_UPPER, 16'h01C7);
    run_cycle(20'hFFFF0, 1'b0, 8'h00, 5);
    $display("test rearm done");
  endtask

  // ****************************************
  // Sequence, watchdog and verdict
  // ****************************************
  task automatic end_of_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    test_reset();
    test_low_mid();
    test_periph();
    test_waits();
    test_rearm();
    end_of_test();
  end
endmodule // tb_top

`default_nettype wire
